// ### verilog/dmt_core.sv
// Purpose: Control, key sequence and status logic of the deadman timer.
// Assumes: Fetch, sleep and configuration inputs are synchronous to clk.
// Notes: A deadman event gives a one-cycle processor reset request.
`timescale 1ns/1ps
module dmt_core import dmt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [DMT_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration word and processor status
  input wire logic fixed_enable_fuse,
  input wire logic [3:0] config_count_sel,
  input wire logic fetch_strobe,
  input wire logic sleep_mode,
  // Recovery
  output logic deadman_reset_o
);
  logic take;
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_pre;
  logic wr_clr;
  logic active;
  logic count_en;
  logic count_clr;
  logic expired_q;
  logic [DMT_CNT_W-1:0] count_q;
  logic [DMT_CNT_W-1:0] match_val;
  logic [DMT_KEY_W-1:0] pre_val;
  logic [DMT_KEY_W-1:0] clr_val;

  logic enable_q;
  logic enable_d;
  logic [DMT_KEY_W-1:0] first_step_field_q;
  logic [DMT_KEY_W-1:0] first_step_field_d;
  logic [DMT_KEY_W-1:0] second_step_field_q;
  logic [DMT_KEY_W-1:0] second_step_field_d;
  dmt_key_st_t key_st_q;
  dmt_key_st_t key_st_d;
  logic first_step_error_flag_set;
  logic second_step_error_flag_set;
  logic clear_ok;

  logic first_step_error_flag_q;
  logic first_step_error_flag_d;
  logic second_step_error_flag_q;
  logic second_step_error_flag_d;
  logic event_q;
  logic event_d;
  logic event_fire;
  logic window_open_indicator_q;
  logic window_open_indicator_d;
  logic reset_q;
  logic reset_d;

  logic [31:0] rdata;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  dmt_wb_slave u_slave (
    .clk(clk),
    .resetn(resetn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o),
    .take(take)
  );

  // Access decode; lanes without a field are dropped
  assign wr = take & wb_we_i;
  assign rd = take & ~wb_we_i;
  assign wr_ctrl = wr & (wb_adr_i == DMT_OFS_CONTROL) & wb_sel_i[DMT_FIRST_STEP_FIELD_LANE];
  assign wr_pre = wr & (wb_adr_i == DMT_OFS_PRECLEAR) & wb_sel_i[DMT_FIRST_STEP_FIELD_LANE];
  assign wr_clr = wr & (wb_adr_i == DMT_OFS_CLEAR) & wb_sel_i[DMT_SECOND_STEP_FIELD_LANE];
  assign pre_val = wb_dat_i[DMT_FIRST_STEP_FIELD_LSB +: DMT_KEY_W];
  assign clr_val = wb_dat_i[DMT_SECOND_STEP_FIELD_LSB +: DMT_KEY_W];

  // Fuse pins the module on, whatever software wrote
  assign active = fixed_enable_fuse | enable_q;

  assign match_val = dmt_timeout(config_count_sel);
  assign count_en = active & fetch_strobe & ~sleep_mode;
  assign count_clr = reset_q | clear_ok | ~active;

  dmt_counter u_counter (
    .clk(clk),
    .resetn(resetn),
    .count_en(count_en),
    .count_clr(count_clr),
    .match_val(match_val),
    .count_q(count_q),
    .expired_q(expired_q)
  );

  // Control register
  always_comb begin
    enable_d = enable_q;
    if (wr_ctrl) begin
      enable_d = wb_dat_i[DMT_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      enable_q <= 1'b0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Two-step key sequence; a write in the reset-event cycle is still captured
  always_comb begin
    first_step_field_d = first_step_field_q;
    second_step_field_d = second_step_field_q;
    key_st_d = key_st_q;
    first_step_error_flag_set = 1'b0;
    second_step_error_flag_set = 1'b0;
    clear_ok = 1'b0;
    if (reset_q) begin
      first_step_field_d = DMT_KEY_ZERO;
      second_step_field_d = DMT_KEY_ZERO;
      key_st_d = DMT_KEY_IDLE;
    end
    if (wr_pre) begin
      first_step_field_d = pre_val;
      if (dmt_key_hit(pre_val, DMT_KEY_PRECLEAR)) begin
        key_st_d = DMT_KEY_ARMED;
      end else begin
        key_st_d = DMT_KEY_IDLE;
        first_step_error_flag_set = 1'b1;
      end
    end
    if (wr_clr) begin
      case (key_st_q)
        DMT_KEY_ARMED: begin
          if (dmt_key_hit(clr_val, DMT_KEY_CLEAR) && !reset_q) begin
            clear_ok = 1'b1;
            first_step_field_d = DMT_KEY_ZERO;
            second_step_field_d = DMT_KEY_ZERO;
            key_st_d = DMT_KEY_IDLE;
          end else begin
            second_step_error_flag_set = 1'b1;
            second_step_field_d = clr_val;
          end
        end
        DMT_KEY_IDLE: begin
          second_step_error_flag_set = 1'b1;
          second_step_field_d = clr_val;
        end
        default: begin
          second_step_error_flag_set = 1'b1;
          second_step_field_d = clr_val;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_step_field_q <= DMT_KEY_ZERO;
      second_step_field_q <= DMT_KEY_ZERO;
      key_st_q <= DMT_KEY_IDLE;
    end else begin
      first_step_field_q <= first_step_field_d;
      second_step_field_q <= second_step_field_d;
      key_st_q <= key_st_d;
    end
  end

  // Status flags: a new set beats the hardware clear in the same cycle
  always_comb begin
    event_fire = active & (expired_q | first_step_error_flag_set | second_step_error_flag_set);
    first_step_error_flag_d = first_step_error_flag_set | (first_step_error_flag_q & ~reset_q);
    second_step_error_flag_d = second_step_error_flag_set | (second_step_error_flag_q & ~reset_q);
    // Event flag survives the processor reset so recovery code can see why
    event_d = event_fire | (event_q & ~clear_ok);
    reset_d = event_fire;
    window_open_indicator_d = active & ~reset_q & (count_q >= dmt_window_start(config_count_sel));
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_step_error_flag_q <= 1'b0;
      second_step_error_flag_q <= 1'b0;
      event_q <= 1'b0;
      reset_q <= 1'b0;
      window_open_indicator_q <= 1'b0;
    end else begin
      first_step_error_flag_q <= first_step_error_flag_d;
      second_step_error_flag_q <= second_step_error_flag_d;
      event_q <= event_d;
      reset_q <= reset_d;
      window_open_indicator_q <= window_open_indicator_d;
    end
  end

  // Read path; unmapped words and unimplemented bits read zero
  always_comb begin
    rdata = DMT_WORD_ZERO;
    case (wb_adr_i)
      DMT_OFS_CONTROL: rdata[DMT_ENABLE_BIT] = enable_q;
      DMT_OFS_PRECLEAR: rdata[DMT_FIRST_STEP_FIELD_LSB +: DMT_KEY_W] = first_step_field_q;
      DMT_OFS_CLEAR: rdata[DMT_SECOND_STEP_FIELD_LSB +: DMT_KEY_W] = second_step_field_q;
      DMT_OFS_STATUS: begin
        rdata[DMT_FIRST_STEP_ERROR_FLAG_BIT] = first_step_error_flag_q;
        rdata[DMT_SECOND_STEP_ERROR_FLAG_BIT] = second_step_error_flag_q;
        rdata[DMT_EVENT_BIT] = event_q;
        rdata[DMT_WINDOW_OPEN_INDICATOR_BIT] = window_open_indicator_q;
      end
      DMT_OFS_COUNT: rdata = count_q;
      default: rdata = DMT_WORD_ZERO;
    endcase
    dat_d = rd ? rdata : DMT_WORD_ZERO;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dat_q <= DMT_WORD_ZERO;
    end else begin
      dat_q <= dat_d;
    end
  end

  assign wb_dat_o = dat_q;
  assign deadman_reset_o = reset_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_good_pre;
    wr_pre && dmt_key_hit(pre_val, DMT_KEY_PRECLEAR) && !wr_clr;
  endsequence

  sequence s_good_clr;
    wr_clr && key_st_q == DMT_KEY_ARMED && dmt_key_hit(clr_val, DMT_KEY_CLEAR) && !reset_q;
  endsequence

  a_ctrl_enable_write: assert property (
    wr_ctrl |=> enable_q == $past(wb_dat_i[DMT_ENABLE_BIT]))
    else $error("enable bit did not follow the control write");

  a_fuse_keeps_count: assert property (
    (fixed_enable_fuse && !enable_q && fetch_strobe && !sleep_mode && !count_clr && count_q < match_val)
    |=> count_q == $past(count_q) + DMT_CNT_ONE)
    else $error("fuse did not keep the counter running");

  // A good key raises no new first-step error flag
  a_preclear_arms: assert property (
    s_good_pre |=> key_st_q == DMT_KEY_ARMED && first_step_field_q == DMT_KEY_PRECLEAR
    && (!first_step_error_flag_q || $past(first_step_error_flag_q)))
    else $error("good first key did not arm");

  a_bad_pre_event: assert property (
    (wr_pre && !dmt_key_hit(pre_val, DMT_KEY_PRECLEAR) && active)
    |=> first_step_error_flag_q && event_q ##1 !first_step_error_flag_q || $past(first_step_error_flag_set))
    else $error("bad first key not flagged");

  a_clear_sequence: assert property (
    s_good_pre ##[1:8] s_good_clr |=> first_step_field_q == DMT_KEY_ZERO && second_step_field_q == DMT_KEY_ZERO
    && count_q == DMT_WORD_ZERO && (!event_q || $past(expired_q)))
    else $error("clear sequence did not clear fields and counter");

  a_bad_clear_keeps: assert property (
    (wr_clr && !reset_q && !wr_pre && !(key_st_q == DMT_KEY_ARMED && dmt_key_hit(clr_val, DMT_KEY_CLEAR)))
    |=> second_step_error_flag_q && first_step_field_q == $past(first_step_field_q) && second_step_field_q == $past(clr_val))
    else $error("bad second key handling wrong");

  a_reset_clears_step: assert property (
    (reset_q && !wr_pre && !wr_clr) |=> first_step_field_q == DMT_KEY_ZERO && second_step_field_q == DMT_KEY_ZERO
    && !first_step_error_flag_q && !second_step_error_flag_q)
    else $error("reset event did not clear step fields and flags");

  a_status_readback: assert property (
    (rd && wb_adr_i == DMT_OFS_STATUS) |=> wb_ack_o && wb_dat_o[DMT_FIRST_STEP_ERROR_FLAG_BIT] == $past(first_step_error_flag_q)
    && wb_dat_o[DMT_EVENT_BIT] == $past(event_q) && wb_dat_o[31:DMT_FIRST_STEP_ERROR_FLAG_BIT+1] == '0)
    else $error("status read back wrong");

  a_expire_resets: assert property (
    (expired_q && active) |=> deadman_reset_o && event_q ##1 !deadman_reset_o || $past(event_fire))
    else $error("expiry did not request a processor reset");

  a_window_open: assert property (
    window_open_indicator_q |-> $past(count_q) >= dmt_window_start($past(config_count_sel)) && $past(active))
    else $error("window open without reaching its start");

  a_sleep_holds: assert property (
    (sleep_mode && !count_clr) |=> count_q == $past(count_q))
    else $error("counter moved during sleep");

  a_count_bounded: assert property (
    count_q <= match_val || $changed(config_count_sel) || $past(count_q) > match_val)
    else $error("counter passed its match value");

  // Wrong second key while on, whatever the sequence state
  sequence s_bad_clr;
    wr_clr && active && !(key_st_q == DMT_KEY_ARMED && dmt_key_hit(clr_val, DMT_KEY_CLEAR));
  endsequence

  a_bad_clr_event: assert property (
    s_bad_clr |=> second_step_error_flag_q && event_q && deadman_reset_o)
    else $error("bad second key gave no event");

  a_bad_pre_disarms: assert property (
    (wr_pre && !dmt_key_hit(pre_val, DMT_KEY_PRECLEAR))
    |=> key_st_q == DMT_KEY_IDLE && first_step_field_q == $past(pre_val))
    else $error("bad first key left the sequence armed");

  a_first_step_error_flag_cause: assert property (
    $rose(first_step_error_flag_q) |-> $past(wr_pre))
    else $error("first-step error flag rose with no preclear write");

  a_second_step_error_flag_cause: assert property (
    $rose(second_step_error_flag_q) |-> $past(wr_clr))
    else $error("second-step error flag rose with no clear write");

  a_first_step_field_holds: assert property (
    (!reset_q && !wr_pre && !clear_ok) |=> first_step_field_q == $past(first_step_field_q))
    else $error("first-step field changed with no cause");

  a_second_step_field_holds: assert property (
    (!reset_q && !wr_clr) |=> second_step_field_q == $past(second_step_field_q))
    else $error("second-step field changed with no cause");

  // Only a good clear may drop the event flag
  a_event_sticky: assert property (
    (event_q && !clear_ok) |=> event_q)
    else $error("event flag dropped without a good clear");

  a_idle_quiet: assert property (
    !active |=> count_q == DMT_WORD_ZERO && !deadman_reset_o)
    else $error("module off yet counting or resetting");

  a_window_opens: assert property (
    (active && !reset_q && count_q >= dmt_window_start(config_count_sel)) |=> window_open_indicator_q)
    else $error("window did not open at its start");

  a_unmapped_zero: assert property (
    (rd && wb_adr_i > DMT_OFS_COUNT) |=> wb_dat_o == DMT_WORD_ZERO)
    else $error("unmapped word did not read zero");

endmodule

// ### common/dmt_pkg.sv
// Purpose: Shared constants, types and helpers of the deadman timer clear logic.
// Assumes: 32-bit classic Wishbone register access, one clock domain.
// Notes: Register offsets are byte addresses of aligned words.
//
// Behaviour
// - Control enable bit turns module on, resets zero
// - Software enable ignored while fixed fuse set
// - First-step key 01000000 arms the preclear
// - Wrong first-step value sets first-step error flag
// - First-step field cleared on reset event, good clear
// - Second key after first clears fields and counter
// - Wrong second key: flag, keep first, store value
// - Second-step field cleared on reset event
// - Status bits 7,6,5 read-only, reset zero, hardware-cleared
// - Event flag on expiry or wrong key; the code sets it only while the module is on
// - Status bit 0 shows clear window open
// - Unimplemented bits read zero, ignore writes
// - Counter advances per fetch, stops in sleep
// - 32-bit counter, match from 4-bit config field
// - Deadman event resets the processor
package dmt_pkg;

  // Register map
  localparam int unsigned DMT_ADR_W = 5;
  localparam logic [4:0] DMT_OFS_CONTROL = 5'h00;
  localparam logic [4:0] DMT_OFS_PRECLEAR = 5'h04;
  localparam logic [4:0] DMT_OFS_CLEAR = 5'h08;
  localparam logic [4:0] DMT_OFS_STATUS = 5'h0c;
  localparam logic [4:0] DMT_OFS_COUNT = 5'h10;
  localparam logic [31:0] DMT_WORD_ZERO = 32'h0000_0000;

  // Field layout
  localparam int unsigned DMT_ENABLE_BIT = 15;
  localparam int unsigned DMT_KEY_W = 8;
  localparam int unsigned DMT_FIRST_STEP_FIELD_LSB = 8;
  localparam int unsigned DMT_SECOND_STEP_FIELD_LSB = 0;
  localparam int unsigned DMT_FIRST_STEP_FIELD_LANE = 1;
  localparam int unsigned DMT_SECOND_STEP_FIELD_LANE = 0;
  localparam int unsigned DMT_FIRST_STEP_ERROR_FLAG_BIT = 7;
  localparam int unsigned DMT_SECOND_STEP_ERROR_FLAG_BIT = 6;
  localparam int unsigned DMT_EVENT_BIT = 5;
  localparam int unsigned DMT_WINDOW_OPEN_INDICATOR_BIT = 0;
  localparam logic [7:0] DMT_KEY_ZERO = 8'h00;

  // Key patterns
  localparam logic [7:0] DMT_KEY_PRECLEAR = 8'h40;
  localparam logic [7:0] DMT_KEY_CLEAR = 8'h08;

  // Counter
  localparam int unsigned DMT_CNT_W = 32;
  localparam logic [31:0] DMT_TIMEOUT_BASE = 32'h0000_0100;
  localparam logic [31:0] DMT_CNT_ONE = 32'h0000_0001;

  typedef enum {DMT_KEY_IDLE, DMT_KEY_ARMED} dmt_key_st_t;

  function automatic logic [31:0] dmt_timeout(input logic [3:0] sel);
    return DMT_TIMEOUT_BASE << sel;
  endfunction

  // Window opens at half the time-out
  function automatic logic [31:0] dmt_window_start(input logic [3:0] sel);
    return dmt_timeout(sel) >> 1;
  endfunction

  function automatic logic dmt_key_hit(input logic [7:0] value, input logic [7:0] key);
    return value == key;
  endfunction

endpackage

// ### verilog/dmt_wb_slave.sv
// Purpose: Classic Wishbone handshake for the deadman register file.
// Assumes: Master holds the request until it sees ack.
// Notes: One wait state; ack lasts exactly one cycle.
`timescale 1ns/1ps
module dmt_wb_slave import dmt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Bus request
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  // Answer
  output logic wb_ack_o,
  output logic take
);
  logic ack_q;
  logic ack_d;

  // Low ack in the cycle after it fires keeps one request from being taken twice
  always_comb begin
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  assign take = ack_d;
  assign wb_ack_o = ack_q;
endmodule

// ### verilog/dmt_counter.sv
// Purpose: Instruction-fetch deadman counter with time-out match.
// Assumes: Enable and clear come from the control logic.
// Notes: Holds at the match value until cleared.
`timescale 1ns/1ps
module dmt_counter import dmt_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic count_en,
  input wire logic count_clr,
  input wire logic [DMT_CNT_W-1:0] match_val,
  // Status
  output logic [DMT_CNT_W-1:0] count_q,
  output logic expired_q
);
  logic [DMT_CNT_W-1:0] count_d;
  logic expired_d;

  always_comb begin
    count_d = count_q;
    expired_d = 1'b0;
    if (count_clr) begin
      count_d = DMT_WORD_ZERO;
    end else if (count_en && count_q < match_val) begin
      count_d = count_q + DMT_CNT_ONE;
      expired_d = (count_d == match_val);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= DMT_WORD_ZERO;
      expired_q <= 1'b0;
    end else begin
      count_q <= count_d;
      expired_q <= expired_d;
    end
  end
endmodule

// ### test/deadman_timer_clear_logic_tb.sv
// Purpose: Self-checking bench for the deadman timer clear logic.
// Assumes: Timeout selector 0 (256 fetches), then 1; one wait state on the bus.
// Notes: Key tests run first with the module off so the error flags persist.
`timescale 1ns/1ps
module deadman_timer_clear_logic_tb import dmt_pkg::*;;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [DMT_ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic fixed_enable_fuse = 1'b0;
  logic [3:0] config_count_sel = 4'h0;
  logic fetch_strobe = 1'b0;
  logic sleep_mode = 1'b0;
  logic deadman_reset_o;
  int mismatches = 0;
  int checked = 0;
  int pulses = 0;

  always #2 clk = ~clk;

  dmt_core i_dmt_core (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fixed_enable_fuse(fixed_enable_fuse), .config_count_sel(config_count_sel),
    .fetch_strobe(fetch_strobe), .sleep_mode(sleep_mode), .deadman_reset_o(deadman_reset_o)
  );

  always @(posedge clk) begin
    if (deadman_reset_o === 1'b1) pulses <= pulses + 1;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle; ack and read data are taken at the same edge
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // No local limit: the watchdog ends a hung access
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r & mask, exp);
  endtask

  task automatic t_reset_values();
    rchk(DMT_OFS_CONTROL, 32'hffff_ffff, 32'h0000_0000);
    rchk(DMT_OFS_PRECLEAR, 32'hffff_ffff, 32'h0000_0000);
    rchk(DMT_OFS_CLEAR, 32'hffff_ffff, 32'h0000_0000);
    rchk(DMT_OFS_STATUS, 32'hffff_ffff, 32'h0000_0000);
    wr(5'h14, 32'hffff_ffff);
    rchk(5'h14, 32'hffff_ffff, 32'h0000_0000);
  endtask

  // Module off: no recovery reset, so the error flags stay visible
  task automatic t_keys_inactive();
    wr(DMT_OFS_PRECLEAR, 32'h0000_4100);
    rchk(DMT_OFS_STATUS, 32'h0000_00c0, 32'h0000_0080);
    wr(DMT_OFS_PRECLEAR, 32'hffff_40ff);
    rchk(DMT_OFS_PRECLEAR, 32'hffff_ffff, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'hffff_ff55);
    rchk(DMT_OFS_CLEAR, 32'hffff_ffff, 32'h0000_0055);
    rchk(DMT_OFS_PRECLEAR, 32'hffff_ffff, 32'h0000_4000);
    wr(DMT_OFS_STATUS, 32'h0000_0000);
    rchk(DMT_OFS_STATUS, 32'hffff_fffe, 32'h0000_00c0);
    wr(DMT_OFS_CLEAR, 32'h0000_0008);
    rchk(DMT_OFS_PRECLEAR, 32'hffff_ffff, 32'h0000_0000);
    rchk(DMT_OFS_CLEAR, 32'hffff_ffff, 32'h0000_0000);
    chk(pulses, 0);
  endtask

  task automatic t_enable();
    wb_sel_i <= 4'h0;
    wr(DMT_OFS_CONTROL, 32'hffff_ffff);
    wb_sel_i <= 4'hf;
    rchk(DMT_OFS_CONTROL, 32'hffff_ffff, 32'h0000_0000);
    wr(DMT_OFS_CONTROL, 32'hffff_ffff);
    rchk(DMT_OFS_CONTROL, 32'hffff_ffff, 32'h0000_8000);
  endtask

  // Module on: each bad key gives one recovery reset
  task automatic t_keys_active();
    wr(DMT_OFS_CLEAR, 32'h0000_0033);
    rchk(DMT_OFS_CLEAR, 32'hffff_ffff, 32'h0000_0000);
    chk(pulses, 1);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_PRECLEAR, 32'h0000_4100);
    rchk(DMT_OFS_PRECLEAR, 32'hffff_ffff, 32'h0000_0000);
    chk(pulses, 2);
    rchk(DMT_OFS_STATUS, 32'h0000_00e0, 32'h0000_0020);
  endtask

  task automatic t_expiry();
    logic [31:0] a;
    logic [31:0] b;
    int n;
    wr(DMT_OFS_PRECLEAR, 32'h0000_4000);
    wr(DMT_OFS_CLEAR, 32'h0000_0008);
    rchk(DMT_OFS_COUNT, 32'hffff_ffff, 32'h0000_0000);
    rchk(DMT_OFS_STATUS, 32'h0000_0021, 32'h0000_0000);
    fetch_strobe <= 1'b1;
    repeat (140) @(posedge clk);
    rchk(DMT_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    sleep_mode <= 1'b1;
    bus(1'b0, DMT_OFS_COUNT, 32'h0000_0000, a);
    repeat (5) @(posedge clk);
    bus(1'b0, DMT_OFS_COUNT, 32'h0000_0000, b);
    chk(b, a);
    chk(pulses, 2);
    sleep_mode <= 1'b0;
    n = 0;
    while (pulses == 2 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(pulses, 3);
    rchk(DMT_OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
  endtask

  // Fuse forces counting with the enable bit cleared
  task automatic t_fuse();
    logic [31:0] r;
    wr(DMT_OFS_CONTROL, 32'h0000_0000);
    rchk(DMT_OFS_COUNT, 32'hffff_ffff, 32'h0000_0000);
    fixed_enable_fuse <= 1'b1;
    repeat (10) @(posedge clk);
    bus(1'b0, DMT_OFS_COUNT, 32'h0000_0000, r);
    // Fetches counted from the edge after the fuse rises to the read's take edge
    chk(r, 32'h0000_000b);
  endtask

  // Selector 1 doubles the time-out: no window near 155, no expiry at 256
  task automatic t_select();
    config_count_sel <= 4'h1;
    repeat (140) @(posedge clk);
    rchk(DMT_OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
    repeat (110) @(posedge clk);
    rchk(DMT_OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
    chk(pulses, 3);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_keys_inactive();
    t_enable();
    t_keys_active();
    t_expiry();
    t_fuse();
    t_select();
    conclude();
  end

  // Expected run is about 650 cycles
  initial begin
    #20000;
    mismatches++;
    conclude();
  end
endmodule
